// ===== verilog/cpm_pkg.sv
/*
  Package for the clock path mode configuration block: register addresses,
  field positions, reset values and decoded mode types.
  Assumes a byte-wide register port with a 10-bit address space.
*/
package cpm_pkg;
  localparam int ADDR_W = 10;
  localparam int DATA_W = 8;
  // Register addresses
  localparam logic [9:0] ADDR_PLL_CTRL = 10'h010;
  localparam logic [9:0] ADDR_CAL_REF = 10'h018;
  localparam logic [9:0] ADDR_REF_EN = 10'h01C;
  localparam logic [9:0] ADDR_OSC_DIV = 10'h1E0;
  localparam logic [9:0] ADDR_SRC_SEL = 10'h1E1;
  localparam logic [9:0] ADDR_UPDATE = 10'h232;
  // Field positions
  localparam int PLL_PWR_LSB = 0;
  localparam int PFD_POL_BIT = 7;
  localparam int CAL_BIT = 0;
  localparam int SRC_OSC_BIT = 1;
  localparam int DIV_BYP_BIT = 0;
  localparam int UPDATE_BIT = 0;
  // Field encodings
  localparam logic [1:0] PLL_PWR_NORMAL = 2'h0;
  localparam logic [1:0] PLL_PWR_DOWN = 2'h1;
  // Reset values
  localparam logic [7:0] RST_PLL_CTRL = 8'h01;
  localparam logic [7:0] RST_CAL_REF = 8'h00;
  localparam logic [7:0] RST_REF_EN = 8'h00;
  localparam logic [7:0] RST_OSC_DIV = 8'h00;
  localparam logic [7:0] RST_SRC_SEL = 8'h00;
  // Calibration sequencer length in cycles
  localparam logic [7:0] CAL_CYCLES = 8'h40;
  localparam logic [2:0] DIV_RATIO_MAX = 3'h6;
  // Calibration sequencer states, Gray coded from idle through run to done
  typedef enum logic [1:0]
  {
    CPM_CAL_IDLE = 2'b00,
    CPM_CAL_RUN = 2'b01,
    CPM_CAL_DONE = 2'b11
  } cpm_cal_type;
endpackage

// ===== verilog/cpm_clock_path.sv
/*
  Clock path mode configuration: shadow and active registers, decoded path
  controls and the oscillator calibration sequencer.
  Assumes a synchronous byte register port already decoded from the serial
  control port, and a nonvolatile store that presents its image at load.
*/
`timescale 1ns/1ps
// How it works
// [R1] PLL power field 00 runs the PLL and 01 puts it in power-down.
// [R2] Source bit one routes the internal oscillator, zero the external clock.
// [R3] Bypass bit zero uses the oscillator divider, one bypasses it.
// [R4] Divider field sets divide one to six, with code 000 dividing by two.
// [R5] Polarity bit zero gives positive, one negative phase detector polarity.
// [R6] Reset leaves PLL down, divider 000, divider in use and external clock.
// [R7] Calibration runs when the calibration bit is one and update is written.
// [R8] Software clears the bit and updates before any later recalibration.
// [R9] Software keeps channel divider input at or below 1600 MHz.
// [R10] Reference inputs are enabled by a three-bit field and start disabled.
// [R11] PLL on with external clock powers off the internal oscillator.
// [R12] Distribution through the divider accepts inputs up to 2400 MHz.
// [R13] A stored nonvolatile image may load the registers without host writes.
// [R14] Writes land in shadow storage and take effect on the update strobe.
module cpm_clock_path
(
  // Clock, reset, enable
  input wire logic ref_clk,
  input wire logic reset_n,
  input wire logic clk_en,
  // Register port
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [cpm_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [cpm_pkg::DATA_W-1:0] reg_wdata,
  output logic [cpm_pkg::DATA_W-1:0] reg_rdata,
  output logic reg_rvalid,
  // Nonvolatile image load
  input wire logic nvm_load,
  input wire logic [cpm_pkg::DATA_W-1:0] nvm_pll_ctrl,
  input wire logic [cpm_pkg::DATA_W-1:0] nvm_ref_en,
  input wire logic [cpm_pkg::DATA_W-1:0] nvm_osc_div,
  input wire logic [cpm_pkg::DATA_W-1:0] nvm_src_sel,
  // Path controls
  output logic pll_power_down,
  output logic pfd_negative,
  output logic src_internal_osc,
  output logic div_bypass,
  output logic [2:0] div_ratio,
  output logic [2:0] ref_enable,
  output logic osc_power_on,
  output logic prescaler_from_ext,
  output logic cal_busy,
  output logic cal_start
);
  import cpm_pkg::*;

  logic [7:0] sh_pll_r, sh_cal_r, sh_ref_r, sh_div_r, sh_src_r;
  logic [7:0] sh_pll_nxt, sh_cal_nxt, sh_ref_nxt, sh_div_nxt, sh_src_nxt;
  logic [7:0] ac_pll_r, ac_cal_r, ac_ref_r, ac_div_r, ac_src_r;
  logic [7:0] ac_pll_nxt, ac_cal_nxt, ac_ref_nxt, ac_div_nxt, ac_src_nxt;
  logic [7:0] rdata_r, rdata_nxt;
  logic rvalid_r, rvalid_nxt;
  cpm_cal_type cal_r, cal_nxt;
  logic [7:0] cal_cnt_r, cal_cnt_nxt;
  logic update_hit;
  logic cal_go;

  // Divider code to ratio: 000 gives two, 001..101 give one, three..six
  function automatic logic [2:0] div_decode(input logic [2:0] code);
    logic [2:0] r;
    r = 3'h2;
    case (code)
      3'h1: r = 3'h1;
      3'h2: r = 3'h3;
      3'h3: r = 3'h4;
      3'h4: r = 3'h5;
      3'h5: r = 3'h6;
      default: r = 3'h2;
    endcase
    return r;
  endfunction

  // Update strobe write
  assign update_hit = reg_wr && (reg_addr == ADDR_UPDATE) && reg_wdata[UPDATE_BIT];

  // Calibration is started by an update that carries the calibration bit
  assign cal_go = update_hit && sh_cal_r[CAL_BIT]; // see [R7]

  // Shadow and active register next values
  always_comb
  begin
    sh_pll_nxt = sh_pll_r;
    sh_cal_nxt = sh_cal_r;
    sh_ref_nxt = sh_ref_r;
    sh_div_nxt = sh_div_r;
    sh_src_nxt = sh_src_r;
    ac_pll_nxt = ac_pll_r;
    ac_cal_nxt = ac_cal_r;
    ac_ref_nxt = ac_ref_r;
    ac_div_nxt = ac_div_r;
    ac_src_nxt = ac_src_r;
    if (nvm_load)
    begin
      // Stored image goes straight to shadow and active copies, see [R13]
      sh_pll_nxt = nvm_pll_ctrl;
      sh_ref_nxt = nvm_ref_en;
      sh_div_nxt = nvm_osc_div;
      sh_src_nxt = nvm_src_sel;
      ac_pll_nxt = nvm_pll_ctrl;
      ac_ref_nxt = nvm_ref_en;
      ac_div_nxt = nvm_osc_div;
      ac_src_nxt = nvm_src_sel;
    end
    else if (reg_wr)
    begin
      // Host writes reach shadow storage; only an update write reaches the active set, see [R14]
      if (reg_addr == ADDR_PLL_CTRL)
        sh_pll_nxt = reg_wdata;
      else if (reg_addr == ADDR_CAL_REF)
        sh_cal_nxt = reg_wdata;
      else if (reg_addr == ADDR_REF_EN)
        sh_ref_nxt = reg_wdata;
      else if (reg_addr == ADDR_OSC_DIV)
        sh_div_nxt = reg_wdata;
      else if (reg_addr == ADDR_SRC_SEL)
        sh_src_nxt = reg_wdata;
      else if (update_hit)
      begin
        // Transfer all shadows to the active set, see [R14]
        ac_pll_nxt = sh_pll_r;
        ac_cal_nxt = sh_cal_r;
        ac_ref_nxt = sh_ref_r;
        ac_div_nxt = sh_div_r;
        ac_src_nxt = sh_src_r;
      end
    end
  end

  // Read data from the shadow set, cal_busy at the update address; unmapped addresses read zero
  always_comb
  begin
    rvalid_nxt = reg_rd;
    rdata_nxt = rdata_r;
    if (reg_rd)
    begin
      if (reg_addr == ADDR_PLL_CTRL)
        rdata_nxt = sh_pll_r;
      else if (reg_addr == ADDR_CAL_REF)
        rdata_nxt = sh_cal_r;
      else if (reg_addr == ADDR_REF_EN)
        rdata_nxt = sh_ref_r;
      else if (reg_addr == ADDR_OSC_DIV)
        rdata_nxt = sh_div_r;
      else if (reg_addr == ADDR_SRC_SEL)
        rdata_nxt = sh_src_r;
      else if (reg_addr == ADDR_UPDATE)
        rdata_nxt = {7'h00, cal_busy};
      else
        rdata_nxt = 8'h00;
    end
  end

  // Calibration sequencer next state
  always_comb
  begin
    cal_nxt = cal_r;
    cal_cnt_nxt = cal_cnt_r;
    case (cal_r)
      CPM_CAL_IDLE:
        if (cal_go)
        begin
          cal_nxt = CPM_CAL_RUN; // see [R7]
          cal_cnt_nxt = CAL_CYCLES;
        end
      CPM_CAL_RUN:
        if (cal_cnt_r == 8'h01)
          cal_nxt = CPM_CAL_DONE;
        else
          cal_cnt_nxt = cal_cnt_r - 8'h01;
      CPM_CAL_DONE:
        // Rearm only after software clears the calibration bit and updates
        if (update_hit && !sh_cal_r[CAL_BIT])
          cal_nxt = CPM_CAL_IDLE; // see [R8]
      default:
        cal_nxt = CPM_CAL_IDLE;
    endcase
  end

  // State registers; reset values give PLL down, external clock, see [R6]
  always_ff @(posedge ref_clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      sh_pll_r <= RST_PLL_CTRL;
      sh_cal_r <= RST_CAL_REF;
      sh_ref_r <= RST_REF_EN;
      sh_div_r <= RST_OSC_DIV;
      sh_src_r <= RST_SRC_SEL;
      ac_pll_r <= RST_PLL_CTRL;
      ac_cal_r <= RST_CAL_REF;
      ac_ref_r <= RST_REF_EN;
      ac_div_r <= RST_OSC_DIV;
      ac_src_r <= RST_SRC_SEL;
      rdata_r <= 8'h00;
      rvalid_r <= 1'b0;
      cal_r <= CPM_CAL_IDLE;
      cal_cnt_r <= 8'h00;
    end
    else if (clk_en)
    begin
      sh_pll_r <= sh_pll_nxt;
      sh_cal_r <= sh_cal_nxt;
      sh_ref_r <= sh_ref_nxt;
      sh_div_r <= sh_div_nxt;
      sh_src_r <= sh_src_nxt;
      ac_pll_r <= ac_pll_nxt;
      ac_cal_r <= ac_cal_nxt;
      ac_ref_r <= ac_ref_nxt;
      ac_div_r <= ac_div_nxt;
      ac_src_r <= ac_src_nxt;
      rdata_r <= rdata_nxt;
      rvalid_r <= rvalid_nxt;
      cal_r <= cal_nxt;
      cal_cnt_r <= cal_cnt_nxt;
    end
  end

  // Decoded path controls from the active set
  assign pll_power_down = (ac_pll_r[PLL_PWR_LSB +: 2] == PLL_PWR_DOWN); // see [R1]
  assign pfd_negative = ac_pll_r[PFD_POL_BIT]; // see [R5]
  assign src_internal_osc = ac_src_r[SRC_OSC_BIT]; // see [R2]
  // Bypass selects the raw source; zero keeps the divider, which takes 2400 MHz, see [R12]
  assign div_bypass = ac_src_r[DIV_BYP_BIT]; // see [R3]
  assign div_ratio = div_decode(ac_div_r[2:0]); // see [R4]
  assign ref_enable = ac_ref_r[2:0]; // see [R10]
  // External clock with PLL on: oscillator off, prescaler fed from outside
  assign osc_power_on = src_internal_osc; // see [R11]
  assign prescaler_from_ext = !src_internal_osc && !pll_power_down; // see [R11]
  assign cal_busy = (cal_r == CPM_CAL_RUN);
  assign cal_start = cal_go && (cal_r == CPM_CAL_IDLE) && clk_en;
  assign reg_rdata = rdata_r;
  assign reg_rvalid = rvalid_r;

  // Assertions
  a_shadow_hold: assert property (@(posedge ref_clk) disable iff (!reset_n) // see [R14]
    (clk_en && reg_wr && reg_addr == ADDR_SRC_SEL && !nvm_load) |=> $stable(ac_src_r))
    else $error("active source changed on a plain write");
  a_update_apply: assert property (@(posedge ref_clk) disable iff (!reset_n) // see [R14]
    (clk_en && update_hit && !nvm_load) |=> ac_pll_r == $past(sh_pll_r))
    else $error("update did not copy shadow");
  a_pll_down_dec: assert property (@(posedge ref_clk) disable iff (!reset_n) // see [R1]
    pll_power_down == (ac_pll_r[1:0] == 2'h1))
    else $error("pll power decode wrong");
  a_src_route: assert property (@(posedge ref_clk) disable iff (!reset_n) // see [R2]
    src_internal_osc == ac_src_r[1])
    else $error("source select wrong");
  a_bypass_route: assert property (@(posedge ref_clk) disable iff (!reset_n) // see [R3]
    div_bypass == ac_src_r[0])
    else $error("bypass select wrong");
  a_div_zero: assert property (@(posedge ref_clk) disable iff (!reset_n) // see [R4]
    (ac_div_r[2:0] == 3'h0) |-> div_ratio == 3'h2)
    else $error("code zero not divide by two");
  a_pfd_pol: assert property (@(posedge ref_clk) disable iff (!reset_n) // see [R5]
    pfd_negative == ac_pll_r[7])
    else $error("polarity wrong");
  a_cal_start: assert property (@(posedge ref_clk) disable iff (!reset_n) // see [R7]
    cal_start |=> cal_busy [*8])
    else $error("calibration did not run");
  a_cal_rearm: assert property (@(posedge ref_clk) disable iff (!reset_n) // see [R8]
    (cal_r == CPM_CAL_DONE && cal_go) |=> cal_r != CPM_CAL_RUN)
    else $error("recalibration without clear");
  a_ext_osc_off: assert property (@(posedge ref_clk) disable iff (!reset_n) // see [R11]
    (!src_internal_osc && !pll_power_down) |-> (!osc_power_on && prescaler_from_ext))
    else $error("oscillator not off on external path");
  a_ref_en: assert property (@(posedge ref_clk) disable iff (!reset_n) // see [R10]
    ref_enable == ac_ref_r[2:0])
    else $error("reference enable wrong");
  // Transfer, load, sequencer and path decode checks
  a_update_ref: assert property (@(posedge ref_clk) disable iff (!reset_n) // see [R14]
    (clk_en && update_hit && !nvm_load) |=> ac_ref_r == $past(sh_ref_r))
    else $error("update did not copy reference shadow");
  a_update_src: assert property (@(posedge ref_clk) disable iff (!reset_n) // see [R14]
    (clk_en && update_hit && !nvm_load) |=> ac_src_r == $past(sh_src_r))
    else $error("update did not copy source shadow");
  a_update_div: assert property (@(posedge ref_clk) disable iff (!reset_n) // see [R14]
    (clk_en && update_hit && !nvm_load) |=> ac_div_r == $past(sh_div_r))
    else $error("update did not copy divider shadow");
  a_nvm_apply: assert property (@(posedge ref_clk) disable iff (!reset_n) // see [R13]
    (clk_en && nvm_load) |=> ac_div_r == $past(nvm_osc_div))
    else $error("stored image not applied");
  a_cal_finish: assert property (@(posedge ref_clk) disable iff (!reset_n) // see [R7]
    $fell(cal_busy) |-> cal_r == CPM_CAL_DONE)
    else $error("calibration ended outside done");
  a_cal_clear: assert property (@(posedge ref_clk) disable iff (!reset_n) // see [R8]
    (clk_en && cal_r == CPM_CAL_IDLE && update_hit && !sh_cal_r[CAL_BIT]) |=> !cal_busy)
    else $error("calibration started with bit clear");
  a_osc_on_path: assert property (@(posedge ref_clk) disable iff (!reset_n) // see [R11]
    src_internal_osc |-> (osc_power_on && !prescaler_from_ext))
    else $error("oscillator path controls wrong");
  a_div_range: assert property (@(posedge ref_clk) disable iff (!reset_n) // see [R4]
    (div_ratio >= 3'h1) && (div_ratio <= DIV_RATIO_MAX))
    else $error("divider ratio out of range");

  c_cal_run: cover property (@(posedge ref_clk) cal_start ##[1:80] cal_r == CPM_CAL_DONE);
  c_pll_on: cover property (@(posedge ref_clk) $fell(pll_power_down));
  c_osc_path: cover property (@(posedge ref_clk) $rose(src_internal_osc));
  c_nvm: cover property (@(posedge ref_clk) nvm_load);
endmodule

// ===== tb/testbench.sv
/*
  Self-checking bench for the clock path block: shadow and active
  registers, decoded path controls, calibration and nonvolatile load.
  Assumes cpm_pkg and cpm_clock_path are compiled first.
*/
`timescale 1ns/1ps
module testbench;
  import cpm_pkg::*;
  // Design ports
  logic ref_clk, reset_n, clk_en, reg_wr, reg_rd, nvm_load, reg_rvalid;
  logic [9:0] reg_addr;
  logic [7:0] reg_wdata, reg_rdata, nvm_pll_ctrl, nvm_ref_en, nvm_osc_div, nvm_src_sel;
  logic pll_power_down, pfd_negative, src_internal_osc, div_bypass;
  logic osc_power_on, prescaler_from_ext, cal_busy, cal_start, cs;
  logic [2:0] div_ratio, ref_enable;
  logic [11:0] ctl;
  logic [7:0] sp, sr, sd, ss, np, nr, nd, ns;
  int errors, n_tests, n, i;
  assign ctl = {pll_power_down, pfd_negative, src_internal_osc, div_bypass, div_ratio,
    ref_enable, osc_power_on, prescaler_from_ext};
  cpm_clock_path dut (.ref_clk(ref_clk), .reset_n(reset_n), .clk_en(clk_en),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .nvm_load(nvm_load),
    .nvm_pll_ctrl(nvm_pll_ctrl), .nvm_ref_en(nvm_ref_en), .nvm_osc_div(nvm_osc_div),
    .nvm_src_sel(nvm_src_sel), .pll_power_down(pll_power_down),
    .pfd_negative(pfd_negative), .src_internal_osc(src_internal_osc),
    .div_bypass(div_bypass), .div_ratio(div_ratio), .ref_enable(ref_enable),
    .osc_power_on(osc_power_on), .prescaler_from_ext(prescaler_from_ext),
    .cal_busy(cal_busy), .cal_start(cal_start));
  // Clock, 8 ns period
  initial
  begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end
  // Divider code to ratio
  function automatic logic [2:0] ratio_of(input logic [2:0] c);
    case (c)
      3'h1: return 3'h1;
      3'h2: return 3'h3;
      3'h3: return 3'h4;
      3'h4: return 3'h5;
      3'h5: return 3'h6;
      default: return 3'h2;
    endcase
  endfunction
  // Expected control vector from register images
  function automatic logic [11:0] exp_ctl(input logic [7:0] p, r, d, s);
    logic pd;
    pd = (p[1:0] == PLL_PWR_DOWN);
    return {pd, p[7], s[1], s[0], ratio_of(d[2:0]), r[2:0], s[1], !s[1] && !pd};
  endfunction
  // Verdict and end of run
  task automatic give_verdict();
    $display("comparisons %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // Compare a control vector
  task automatic chk_ctl(input logic [11:0] e, input string m);
    n_tests++;
    if (ctl !== e)
    begin
      errors++;
      $display("wrong value at %0t: %s got %h exp %h", $time, m, ctl, e);
    end
  endtask
  // Compare a byte
  task automatic chk_byte(input logic [7:0] g, e, input string m);
    n_tests++;
    if (g !== e)
    begin
      errors++;
      $display("wrong value at %0t: %s got %h exp %h", $time, m, g, e);
    end
  endtask
  // Register write; cs holds cal_start seen while the write is presented
  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    #1 cs = cal_start;
    @(posedge ref_clk);
    reg_wr <= 1'b0;
  endtask
  // Register read and compare
  task automatic rd(input logic [9:0] a, input logic [7:0] e);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge ref_clk);
    reg_rd <= 1'b0;
    #1 chk_byte({7'h0, reg_rvalid}, 8'h01, "read valid");
    chk_byte(reg_rdata, e, "read data");
  endtask
  // Calibration step: write the bit, update, measure busy length
  task automatic cal_seq(input logic [7:0] cv, input logic es, input int len);
    wr(ADDR_CAL_REF, cv);
    wr(ADDR_UPDATE, 8'h01);
    chk_byte({7'h0, cs}, {7'h0, es}, "calibration start");
    #1 n = 0;
    while (cal_busy === 1'b1 && n < 200)
    begin
      n++;
      @(posedge ref_clk);
      #1;
    end
    if (n >= 200)
    begin
      errors++;
      $display("wrong value at %0t: calibration never ends", $time);
      give_verdict();
    end
    chk_byte(n[7:0], len[7:0], "busy length");
  endtask
  // Main sequence
  initial
  begin
    {reset_n, reg_wr, reg_rd, nvm_load, reg_addr, reg_wdata} = '0;
    {nvm_pll_ctrl, nvm_ref_en, nvm_osc_div, nvm_src_sel} = '0;
    clk_en = 1'b1;
    errors = 0;
    n_tests = 0;
    n = $urandom(35056);
    repeat (10) @(posedge ref_clk);
    reset_n <= 1'b1;
    #1 chk_ctl(exp_ctl(RST_PLL_CTRL, RST_REF_EN, RST_OSC_DIV, RST_SRC_SEL), "reset");
    chk_byte({7'h0, cal_busy}, 8'h00, "reset busy");
    rd(ADDR_PLL_CTRL, RST_PLL_CTRL);
    rd(ADDR_OSC_DIV, RST_OSC_DIV);
    rd(ADDR_SRC_SEL, RST_SRC_SEL);
    rd(ADDR_REF_EN, RST_REF_EN);
    rd(10'h3FF, 8'h00);
    $display("test reset done");
    {sp, sr, sd, ss} = {RST_PLL_CTRL, RST_REF_EN, RST_OSC_DIV, RST_SRC_SEL};
    // Random settings, first pass is PLL on with the external clock
    for (i = 0; i < 16; i++)
    begin
      np = 8'($urandom);
      nr = 8'($urandom);
      nd = {5'($urandom), 3'(i)};
      ns = 8'($urandom);
      if (i == 0)
      begin
        np[1:0] = PLL_PWR_NORMAL;
        ns[SRC_OSC_BIT] = 1'b0;
      end
      // Internal oscillator always goes through the divider
      ns[DIV_BYP_BIT] = ns[DIV_BYP_BIT] && !ns[SRC_OSC_BIT];
      wr(ADDR_PLL_CTRL, np);
      wr(ADDR_REF_EN, nr);
      wr(ADDR_OSC_DIV, nd);
      wr(ADDR_SRC_SEL, ns);
      wr(10'h011, 8'($urandom));
      wr(ADDR_UPDATE, 8'($urandom) & 8'hFE);
      #1 chk_ctl(exp_ctl(sp, sr, sd, ss), "held before update");
      rd(ADDR_PLL_CTRL, np);
      rd(ADDR_SRC_SEL, ns);
      wr(ADDR_UPDATE, 8'h01);
      #1 chk_ctl(exp_ctl(np, nr, nd, ns), "after update");
      {sp, sr, sd, ss} = {np, nr, nd, ns};
    end
    $display("test update done");
    // Clock enable low: nothing lands
    @(posedge ref_clk);
    clk_en <= 1'b0;
    wr(ADDR_SRC_SEL, {ss[7:2], ~ss[1], 1'b0});
    wr(ADDR_UPDATE, 8'h01);
    #1 chk_ctl(exp_ctl(sp, sr, sd, ss), "frozen");
    @(posedge ref_clk);
    clk_en <= 1'b1;
    rd(ADDR_SRC_SEL, ss);
    $display("test freeze done");
    // First calibration, refused rerun, clear, then rerun
    cal_seq(8'h01, 1'b1, CAL_CYCLES);
    rd(ADDR_UPDATE, 8'h00);
    cal_seq(8'h01, 1'b0, 0);
    cal_seq(8'h00, 1'b0, 0);
    cal_seq(8'h01, 1'b1, CAL_CYCLES);
    $display("test calibration done");
    // Stored image load
    np = 8'($urandom);
    nr = 8'($urandom);
    nd = 8'($urandom);
    ns = 8'($urandom);
    ns[DIV_BYP_BIT] = ns[DIV_BYP_BIT] && !ns[SRC_OSC_BIT];
    @(posedge ref_clk);
    {nvm_pll_ctrl, nvm_ref_en, nvm_osc_div, nvm_src_sel} <= {np, nr, nd, ns};
    nvm_load <= 1'b1;
    @(posedge ref_clk);
    nvm_load <= 1'b0;
    #1 chk_ctl(exp_ctl(np, nr, nd, ns), "nonvolatile load");
    rd(ADDR_OSC_DIV, nd);
    $display("test load done");
    // Reset again in mid run
    @(posedge ref_clk);
    reset_n <= 1'b0;
    repeat (2) @(posedge ref_clk);
    reset_n <= 1'b1;
    #1 chk_ctl(exp_ctl(RST_PLL_CTRL, RST_REF_EN, RST_OSC_DIV, RST_SRC_SEL), "reset 2");
    rd(ADDR_REF_EN, RST_REF_EN);
    $display("test mid reset done");
    give_verdict();
  end
endmodule
